// ==== rtl/fpr_pkg.sv ====
// Purpose: Shared constants for the flash program and reload block
// Assumes: 32-bit register port, byte addresses as printed
// Notes:   Timing counts derived from the 200 MHz clock
package fpr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_FLASH_WRITE_PROTECT = 16'hef2c;
  localparam logic [15:0] OFS_FLASH_BYTE_PORT     = 16'hef30;
  localparam logic [15:0] OFS_RELOAD_TRIGGER      = 16'hef34;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          WP_BIT           = 0;
  localparam int          BUSY_BIT         = 8;
  localparam logic        WP_RESET         = 1'b1;
  localparam logic [7:0]  BYTE_PORT_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int SCK_HALF_NS       = 20;
  localparam int SCK_HALF_CYC      = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int RELOAD_PULSE_NS   = 100;
  localparam int RELOAD_PULSE_CYC  = (RELOAD_PULSE_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_READ = 2'b01,
    LD_DONE = 2'b10
  } fpr_ld_state_t;

endpackage : fpr_pkg

// ==== rtl/fpr_shift_if.sv ====
// Purpose: Link between register front end and byte shifter
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/100ps
interface fpr_shift_if;
  logic       start;
  logic [7:0] data;
  logic       busy;
  modport ctl (output start, output data, input busy);
  modport shf (input start, input data, output busy);
endinterface : fpr_shift_if

// ==== rtl/fpr_shifter.sv ====
// Purpose: Serialise one byte onto the flash serial link
// Assumes: Mode 0 style clock, idle low
// Notes:   MSB first; data changes on falling clock
`timescale 1ns/100ps
module fpr_shifter #(
  parameter int HALF_CYC = fpr_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control side
  fpr_shift_if.shf  sif,
  // Serial pins
  output logic      spi_sck,
  output logic      spi_mosi
);

  logic [7:0] sh_ff;
  logic [3:0] bits_ff;
  logic [7:0] div_ff;
  logic       busy_ff;

  assign sif.busy = busy_ff;

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_ff    <= 8'h00;
      bits_ff  <= 4'h0;
      div_ff   <= 8'h00;
      busy_ff  <= 1'b0;
      spi_sck  <= 1'b0;
      spi_mosi <= 1'b0;
    end else if (!busy_ff) begin
      spi_sck <= 1'b0;
      if (sif.start) begin
        busy_ff  <= 1'b1;
        sh_ff    <= {sif.data[6:0], 1'b0};
        spi_mosi <= sif.data[7];
        bits_ff  <= 4'h8;
        div_ff   <= 8'(HALF_CYC - 1);
      end
    end else if (div_ff != 8'h00) begin
      div_ff <= div_ff - 8'h01;
    end else begin
      div_ff  <= 8'(HALF_CYC - 1);
      spi_sck <= ~spi_sck;
      if (spi_sck) begin
        bits_ff <= bits_ff - 4'h1;
        if (bits_ff == 4'h1) begin
          busy_ff <= 1'b0;
        end else begin
          spi_mosi <= sh_ff[7];
          sh_ff    <= {sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sck_idle_low: assert property (@(posedge mclk)
    disable iff (sys_rst) !busy_ff |-> !spi_sck)
    else $error("Serial clock not idle low");
  chk_msb_first: assert property (@(posedge mclk) disable iff (sys_rst)
    (sif.start && !busy_ff) |=> spi_mosi == $past(sif.data[7]))
    else $error("First bit is not MSB");
  cov_byte_done: cover property (@(posedge mclk) disable iff (sys_rst)
    $fell(busy_ff));

endmodule : fpr_shifter

// ==== rtl/fpr_top.sv ====
// Purpose: Flash program path, reload trigger and power-on image load
// Assumes: Synchronous single-cycle register port on mclk
// Notes:   Software polls busy before each byte write
//
// Behaviour
// - Write-protect bit blocks all flash writes
// - Byte port write shifts byte to flash
// - Reload write resets, reloads ROM, reconfigures PLL
// - Power-on clears buffer, registers to defaults
// - Load image chosen by jumper at power-on
`timescale 1ns/100ps
module fpr_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Image selection and loader
  input  wire logic        image_select_jumper,
  input  wire logic        load_done,
  output logic             load_start,
  output logic             load_fallback_image,
  // Board actions
  output logic             sw_reset_pulse,
  output logic             rom_reload_pulse,
  output logic             pll_reconfig_pulse,
  output logic             out_buf_clear,
  // Flash serial link
  output logic             spi_cs_n,
  output logic             spi_sck,
  output logic             spi_mosi
);

  fpr_shift_if sif ();

  logic                       wp_ff;
  logic [7:0]                 byte_ff;
  logic                       start_ff;
  logic [7:0]                 rl_cnt_ff;
  fpr_pkg::fpr_ld_state_t     ld_ff;
  logic                       wr_wp;
  logic                       wr_byte;
  logic                       wr_rl;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // One strobe qualified by an exact address
  function automatic logic addr_hit(input logic        strobe,
                                    input logic [15:0] addr,
                                    input logic [15:0] ofs);
    return strobe && (addr == ofs);
  endfunction : addr_hit

  assign wr_wp   = addr_hit(reg_wr, reg_addr,
                            fpr_pkg::OFS_FLASH_WRITE_PROTECT);
  assign wr_byte = addr_hit(reg_wr, reg_addr,
                            fpr_pkg::OFS_FLASH_BYTE_PORT);
  assign wr_rl   = addr_hit(reg_wr, reg_addr,
                            fpr_pkg::OFS_RELOAD_TRIGGER);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_ff <= fpr_pkg::WP_RESET;
    end else if (wr_wp) begin
      wp_ff <= reg_wdata[fpr_pkg::WP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Byte port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_ff  <= fpr_pkg::BYTE_PORT_RESET;
      start_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (wr_byte && !wp_ff && !sif.busy && !start_ff) begin
        byte_ff  <= reg_wdata[7:0];
        start_ff <= 1'b1;
      end
    end
  end

  assign sif.start = start_ff;
  assign sif.data  = byte_ff;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        fpr_pkg::OFS_FLASH_WRITE_PROTECT:
          reg_rdata <= {31'h0000_0000, wp_ff};
        fpr_pkg::OFS_FLASH_BYTE_PORT:
          reg_rdata <= {23'h00_0000, sif.busy || start_ff, byte_ff};
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reload trigger
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rl_cnt_ff <= 8'h00;
    end else if (wr_rl) begin
      rl_cnt_ff <= 8'(fpr_pkg::RELOAD_PULSE_CYC);
    end else if (rl_cnt_ff != 8'h00) begin
      rl_cnt_ff <= rl_cnt_ff - 8'h01;
    end
  end

  assign sw_reset_pulse     = rl_cnt_ff != 8'h00;
  assign rom_reload_pulse   = rl_cnt_ff != 8'h00;
  assign pll_reconfig_pulse = rl_cnt_ff != 8'h00;

  // ----------------------------------------------------------------
  // Power-on image load
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ld_ff               <= fpr_pkg::LD_IDLE;
      load_fallback_image <= 1'b0;
    end else begin
      case (ld_ff)
        fpr_pkg::LD_IDLE: begin
          load_fallback_image <= image_select_jumper;
          ld_ff               <= fpr_pkg::LD_READ;
        end
        fpr_pkg::LD_READ: begin
          if (load_done) begin
            ld_ff <= fpr_pkg::LD_DONE;
          end
        end
        fpr_pkg::LD_DONE: ld_ff <= fpr_pkg::LD_DONE;
        default:          ld_ff <= fpr_pkg::LD_IDLE;
      endcase
    end
  end

  assign load_start    = ld_ff == fpr_pkg::LD_READ;
  assign out_buf_clear = ld_ff != fpr_pkg::LD_DONE;
  assign spi_cs_n      = !(sif.busy || start_ff);

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  fpr_shifter u_shf (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .sif      (sif.shf),
    .spi_sck  (spi_sck),
    .spi_mosi (spi_mosi)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_wp_blocks: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_byte && wp_ff) |=> !start_ff)
    else $error("Byte started while protected");
  chk_byte_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_byte && !wp_ff && !sif.busy && !start_ff) |=> start_ff
      && byte_ff == $past(reg_wdata[7:0]))
    else $error("Byte write did not start shift");
  chk_busy_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_byte && (sif.busy || start_ff)) |=> !start_ff && $stable(byte_ff))
    else $error("Byte taken while transfer running");
  chk_start_once: assert property (@(posedge mclk) disable iff (sys_rst)
    start_ff |=> !start_ff)
    else $error("Start held longer than one cycle");
  chk_reload_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_rl ##1 !wr_rl [*3]) |-> sw_reset_pulse && pll_reconfig_pulse)
    else $error("Reload pulse too short");
  chk_reload_fire: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_rl |=> rom_reload_pulse)
    else $error("Reload not started");
  chk_reload_end: assert property (@(posedge mclk) disable iff (sys_rst)
    (rl_cnt_ff == 8'h01 && !wr_rl) |=>
      !(sw_reset_pulse || rom_reload_pulse || pll_reconfig_pulse))
    else $error("Reload pulse did not end");
  chk_reload_rd: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_rd && reg_addr == fpr_pkg::OFS_RELOAD_TRIGGER) |=>
      reg_rdata == 32'h0000_0000)
    else $error("Write-only reload register read back");
  chk_buf_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(out_buf_clear) |-> $past(load_done) && $past(load_start))
    else $error("Buffer released before image load");
  chk_buf_stays: assert property (@(posedge mclk) disable iff (sys_rst)
    !out_buf_clear |=> !out_buf_clear)
    else $error("Buffer clear returned without reset");
  chk_image_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (ld_ff == fpr_pkg::LD_IDLE) |=>
      load_fallback_image == $past(image_select_jumper))
    else $error("Wrong image selected");
  chk_image_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (ld_ff != fpr_pkg::LD_IDLE) |=> $stable(load_fallback_image))
    else $error("Image choice changed after power-on");
  chk_load_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (ld_ff == fpr_pkg::LD_DONE) |=> ld_ff == fpr_pkg::LD_DONE)
    else $error("Loader left done state");
  chk_no_overlap: assert property (@(posedge mclk) disable iff (sys_rst)
    start_ff |=> sif.busy)
    else $error("Shifter did not take byte");
  chk_cs_active: assert property (@(posedge mclk) disable iff (sys_rst)
    (spi_sck || $changed(spi_mosi)) |-> !spi_cs_n)
    else $error("Link active without select");
  cov_byte_sent: cover property (@(posedge mclk) disable iff (sys_rst)
    start_ff ##[1:100] !sif.busy);
  cov_reload: cover property (@(posedge mclk) disable iff (sys_rst) wr_rl);
  cov_fallback: cover property (@(posedge mclk) disable iff (sys_rst)
    load_fallback_image && load_done);
  cov_primary: cover property (@(posedge mclk) disable iff (sys_rst)
    !load_fallback_image && load_start && load_done);

endmodule : fpr_top

// ==== verification/fpr_flash_model.sv ====
// Purpose: Behavioural serial flash that captures written bytes
// Assumes: Mode 0 link, chip select active low
// Notes:   Received bytes land in rx_q
`timescale 1ns/100ps
module fpr_flash_model (
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi
);
  logic [7:0] sr_ff;
  int         nbit_ff;
  logic [7:0] rx_q[$];

  initial nbit_ff = 0;

  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      sr_ff = {sr_ff[6:0], spi_mosi};
      nbit_ff = nbit_ff + 1;
      if (nbit_ff == 8) begin
        rx_q.push_back(sr_ff);
        nbit_ff = 0;
      end
    end
  end

  always @(posedge spi_cs_n) nbit_ff = 0;
endmodule : fpr_flash_model

// ==== verification/flash_program_and_reload_bench.sv ====
// Purpose: Self-checking bench for the flash program block
// Assumes: Register port driven on the falling clock edge
// Notes:   Expected bytes kept in a queue
`timescale 1ns/100ps
module flash_program_and_reload_bench;
  logic        mclk, sys_rst, reg_wr, reg_rd, image_select_jumper;
  logic        load_done, load_start, load_fallback_image, out_buf_clear;
  logic        sw_reset_pulse, rom_reload_pulse, pll_reconfig_pulse;
  logic        spi_cs_n, spi_sck, spi_mosi;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, v;
  logic [7:0]  b, exp_q[$];
  int          miscompares, num_checks, cyc, n;

  fpr_top dut (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .image_select_jumper (image_select_jumper),
    .load_done           (load_done),
    .load_start          (load_start),
    .load_fallback_image (load_fallback_image),
    .sw_reset_pulse      (sw_reset_pulse),
    .rom_reload_pulse    (rom_reload_pulse),
    .pll_reconfig_pulse  (pll_reconfig_pulse),
    .out_buf_clear       (out_buf_clear),
    .spi_cs_n            (spi_cs_n),
    .spi_sck             (spi_sck),
    .spi_mosi            (spi_mosi)
  );
  fpr_flash_model flash (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
                         .spi_mosi(spi_mosi));

  always #2.5 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(fpr_pkg::OFS_FLASH_BYTE_PORT);
      k++;
    end while (v[8] !== 1'b0 && k < 100);
    chk(v[8], 1'b0);
  endtask : wait_idle

  task automatic cmp_flash();
    chk(flash.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(flash.rx_q[i], exp_q[i]);
  endtask : cmp_flash

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    load_done = 1'b0;
    seed = 32'd18791;
    v = xs();
    image_select_jumper = v[0];
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    // ----------------------------------------
    // Power-on load and defaults
    // ----------------------------------------
    repeat (4) @(negedge mclk);
    chk(out_buf_clear, 1'b1);
    chk(load_start, 1'b1);
    chk(load_fallback_image, image_select_jumper);
    load_done = 1'b1;
    repeat (3) @(negedge mclk);
    chk(out_buf_clear, 1'b0);
    rd(fpr_pkg::OFS_FLASH_WRITE_PROTECT);
    chk(v[0], fpr_pkg::WP_RESET);
    wr(fpr_pkg::OFS_FLASH_BYTE_PORT, 32'h0000_005a);
    repeat (80) @(negedge mclk);
    cmp_flash();
    $display("test power_on done");
    // ----------------------------------------
    // Unprotected bytes, one refused while busy
    // ----------------------------------------
    wr(fpr_pkg::OFS_FLASH_WRITE_PROTECT, 32'h0000_0000);
    rd(fpr_pkg::OFS_FLASH_WRITE_PROTECT);
    chk(v[0], 1'b0);
    for (int i = 0; i < 4; i++) begin
      b = 8'(xs());
      wr(fpr_pkg::OFS_FLASH_BYTE_PORT, {24'h0, b});
      exp_q.push_back(b);
      if (i == 1) wr(fpr_pkg::OFS_FLASH_BYTE_PORT, {24'h0, ~b});
      wait_idle();
      chk(v[7:0], b);
    end
    cmp_flash();
    wr(fpr_pkg::OFS_FLASH_WRITE_PROTECT, 32'h0000_0001);
    wr(fpr_pkg::OFS_FLASH_BYTE_PORT, {24'h0, b});
    repeat (80) @(negedge mclk);
    cmp_flash();
    $display("test byte_port done");
    // ----------------------------------------
    // Reload and unmapped read
    // ----------------------------------------
    wr(fpr_pkg::OFS_RELOAD_TRIGGER, xs());
    n = 0;
    repeat (30) begin
      if (sw_reset_pulse && rom_reload_pulse && pll_reconfig_pulse) n++;
      @(negedge mclk);
    end
    chk(n, fpr_pkg::RELOAD_PULSE_CYC);
    chk({sw_reset_pulse, rom_reload_pulse, pll_reconfig_pulse}, 3'b000);
    rd(fpr_pkg::OFS_RELOAD_TRIGGER);
    chk(v, 32'h0000_0000);
    rd(16'hef40);
    chk(v, 32'h0000_0000);
    $display("test reload done");
    // ----------------------------------------
    // Mid-run reset with the other image
    // ----------------------------------------
    wr(fpr_pkg::OFS_FLASH_WRITE_PROTECT, 32'h0000_0000);
    @(negedge mclk);
    sys_rst = 1'b1;
    load_done = 1'b0;
    image_select_jumper = ~image_select_jumper;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk(load_start, 1'b1);
    chk(load_fallback_image, image_select_jumper);
    rd(fpr_pkg::OFS_FLASH_WRITE_PROTECT);
    chk(v[0], fpr_pkg::WP_RESET);
    chk(out_buf_clear, 1'b1);
    load_done = 1'b1;
    repeat (3) @(negedge mclk);
    chk(out_buf_clear, 1'b0);
    $display("test mid_reset done");
    close_out();
  end
endmodule : flash_program_and_reload_bench
